// [verilog/sarc_pkg.sv]
package sarc_pkg;

  // ***************************
  // Resolution
  // ***************************
  localparam int SARC_BITS = 8;
  localparam int SARC_STEPS = 256;
  localparam int SARC_SUB = 4;
  localparam int SARC_VIN_W = 10;
  localparam int SARC_HALF_LSB = 2;
  localparam int SARC_TOP_CODE = 255;

  // ***************************
  // Timing
  // ***************************
  localparam int SARC_CLK_PERIOD_PS = 8000;
  localparam int SARC_RC_FREQ_KHZ = 640;
  localparam int SARC_RC_HALF_CYC =
    (1000000000 / (SARC_RC_FREQ_KHZ * 2)) / SARC_CLK_PERIOD_PS;
  localparam int SARC_SCHMITT_NS = 16;
  localparam int SARC_SCHMITT_CYC =
    (SARC_SCHMITT_NS * 1000 + SARC_CLK_PERIOD_PS - 1) / SARC_CLK_PERIOD_PS;

  // ***************************
  // Reset and start values
  // ***************************
  localparam logic [7:0] SARC_DATA_RST = 8'h00;
  localparam logic SARC_DONE_N_RST = 1'b1;
  localparam logic [7:0] SARC_FIRST_TRIAL = 8'h80;

  // ***************************
  // Carriers
  // ***************************
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ext_clk;
  } sarc_pins_t;

  typedef struct packed {
    logic [7:0] data;
    logic oe;
  } sarc_bus_t;

endpackage

// [verilog/sarc_sar.sv]
`timescale 1ns/1ps
module sarc_sar
  import sarc_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic [SARC_VIN_W-1:0] i_vin,
  // Result
  output logic o_busy,
  output logic o_done,
  output logic [SARC_BITS-1:0] o_code
);

  logic busy_q;
  logic done_q;
  logic [2:0] idx_q;
  logic [SARC_BITS-1:0] trial_q;

  // Threshold sits half a step below each code, so 00->01 falls at +1/2 step
  function automatic logic keep_bit(input logic [SARC_VIN_W-1:0] vin,
                                    input logic [SARC_BITS-1:0] trial);
    logic [SARC_VIN_W:0] thr;
    thr = {1'b0, trial, 2'b00} - (SARC_VIN_W+1)'(SARC_HALF_LSB);
    keep_bit = {1'b0, vin} >= thr; // see RULE8, RULE9
  endfunction

  // ***************************
  // Bit trials
  // ***************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      idx_q <= 3'h0;
      trial_q <= SARC_DATA_RST;
    end else if (i_start) begin // see RULE1
      busy_q <= 1'b1;
      idx_q <= 3'h7;
      trial_q <= SARC_FIRST_TRIAL;
    end else if (busy_q && i_tick) begin // see RULE7
      if (!keep_bit(i_vin, trial_q)) begin
        trial_q[idx_q] <= 1'b0;
      end
      if (idx_q != 3'h0) begin
        trial_q[idx_q - 3'h1] <= 1'b1;
      end
      idx_q <= idx_q - 3'h1;
      busy_q <= (idx_q != 3'h0);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && i_tick && !i_start && (idx_q == 3'h0);
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_code = trial_q;

endmodule // sarc_sar

// [verilog/sarc_conv_ctrl.sv]
`timescale 1ns/1ps
// Contract
// RULE1 - Strobe during conversion aborts and restarts
// RULE2 - Aborted conversion leaves output latch untouched
// RULE3 - Done output stays high across restart
// RULE4 - Free-run: select low, strobe tied done
// RULE5 - Free-run: force node low after power-up
// RULE6 - Conversion clock external or own RC
// RULE7 - Span quantised into 256 equal steps
// RULE8 - First transition at half step
// RULE9 - Last transition 1.5 steps below top
// RULE10 - Upper nibble high bits, lower nibble low
// RULE11 - Host stores sixteen results consecutively
// RULE12 - Host stretches cycles at high rates
// RULE13 - Completion latches result, done low; cleared
module sarc_conv_ctrl
  import sarc_pkg::*;
#(
  parameter int RC_HALF_CYC = SARC_RC_HALF_CYC,
  parameter int SCHMITT_CYC = SARC_SCHMITT_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Device pins
  input wire sarc_pins_t i_pins,
  input wire logic i_clk_sel_ext,
  input wire logic [SARC_VIN_W-1:0] i_vin,
  // Outputs
  output sarc_bus_t o_bus,
  output logic o_conversion_done_n,
  output logic o_busy
);

  // ***************************
  // Pin synchronisers
  // ***************************
  sarc_pins_t pins_s1_q;
  sarc_pins_t pins_s2_q;
  logic sel_s1_q;
  logic sel_s2_q;
  logic [SARC_VIN_W-1:0] vin_s1_q;
  logic [SARC_VIN_W-1:0] vin_s2_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pins_s1_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ext_clk: 1'b0};
      pins_s2_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ext_clk: 1'b0};
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end else begin
      pins_s1_q <= i_pins;
      pins_s2_q <= pins_s1_q;
      sel_s1_q <= i_clk_sel_ext;
      sel_s2_q <= sel_s1_q;
    end
  end

  // Analog code assumed quiet near the hold point
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      vin_s1_q <= '0;
      vin_s2_q <= '0;
    end else begin
      vin_s1_q <= i_vin;
      vin_s2_q <= vin_s1_q;
    end
  end

  // ***************************
  // Conversion clock sources
  // ***************************
  logic [7:0] sch_cnt_q;
  logic ext_lvl_q;
  logic ext_prev_q;
  logic [15:0] rc_cnt_q;
  logic rc_lvl_q;
  logic rc_prev_q;
  logic ext_rise;
  logic rc_rise;
  logic conv_tick;

  // Hysteresis: level flips only after a stable run of the new value
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sch_cnt_q <= 8'h00;
      ext_lvl_q <= 1'b0;
    end else if (pins_s2_q.ext_clk == ext_lvl_q) begin
      sch_cnt_q <= 8'h00;
    end else if (sch_cnt_q == 8'(SCHMITT_CYC - 1)) begin // see RULE6
      sch_cnt_q <= 8'h00;
      ext_lvl_q <= pins_s2_q.ext_clk;
    end else begin
      sch_cnt_q <= sch_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rc_cnt_q <= 16'h0000;
      rc_lvl_q <= 1'b0;
    end else if (rc_cnt_q == 16'(RC_HALF_CYC - 1)) begin
      rc_cnt_q <= 16'h0000;
      rc_lvl_q <= !rc_lvl_q;
    end else begin
      rc_cnt_q <= rc_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ext_prev_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_lvl_q;
      rc_prev_q <= rc_lvl_q;
    end
  end

  assign ext_rise = ext_lvl_q && !ext_prev_q;
  assign rc_rise = rc_lvl_q && !rc_prev_q;
  assign conv_tick = sel_s2_q ? ext_rise : rc_rise; // see RULE6

  // ***************************
  // Start strobe
  // ***************************
  logic wr_low;
  logic rd_low;
  logic armed_q;
  logic sar_start;
  logic [SARC_VIN_W-1:0] vin_hold_q;

  assign wr_low = !pins_s2_q.cs_n && !pins_s2_q.wr_n;
  assign rd_low = !pins_s2_q.cs_n && !pins_s2_q.rd_n;
  // Start fires on the return high, matching a real write strobe
  assign sar_start = armed_q && !wr_low; // see RULE1

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= wr_low;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      vin_hold_q <= '0;
    end else if (sar_start) begin
      vin_hold_q <= vin_s2_q;
    end
  end

  // ***************************
  // Approximation engine
  // ***************************
  logic sar_busy;
  logic sar_done;
  logic sar_tick;
  logic [SARC_BITS-1:0] sar_code;

  // Strobe low freezes the trials, so an interrupted result never lands
  assign sar_tick = conv_tick && !wr_low; // see RULE2

  sarc_sar u_sar (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(sar_start),
    .i_tick(sar_tick),
    .i_vin(vin_hold_q),
    .o_busy(sar_busy),
    .o_done(sar_done),
    .o_code(sar_code)
  );

  // ***************************
  // Result latch and done flag
  // ***************************
  logic [SARC_BITS-1:0] data_q;
  logic done_n_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      data_q <= SARC_DATA_RST;
    end else if (sar_done) begin // see RULE2
      data_q <= sar_code; // see RULE13
    end
  end

  // Completion beats a clearing read or strobe in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_n_q <= SARC_DONE_N_RST;
    end else if (sar_done) begin // see RULE13
      done_n_q <= 1'b0;
    end else if (wr_low || rd_low || sar_start) begin // see RULE3
      done_n_q <= 1'b1;
    end
  end

  assign o_bus.data = {data_q[7:4], data_q[3:0]}; // see RULE10
  assign o_bus.oe = rd_low;
  assign o_conversion_done_n = done_n_q;
  assign o_busy = sar_busy;

  // ***************************
  // Checks
  // ***************************
  function automatic logic [SARC_BITS-1:0] quant_ref(input logic [SARC_VIN_W-1:0] v);
    logic [SARC_VIN_W:0] s;
    s = {1'b0, v} + (SARC_VIN_W+1)'(SARC_HALF_LSB);
    quant_ref = (s[SARC_VIN_W:2] > (SARC_VIN_W-1)'(SARC_TOP_CODE)) ?
      8'hFF : s[9:2];
  endfunction

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  restart_keeps_busy_a: assert property (sar_start |=> sar_busy) // see RULE1
    else $error("restart did not begin a new conversion");
  abort_no_latch_a: assert property (!$stable(data_q) |-> $past(sar_done)) // see RULE2
    else $error("result latch changed without completion");
  done_high_busy_a: assert property (sar_busy |-> done_n_q) // see RULE3
    else $error("done low during conversion");
  ext_hysteresis_a: assert property (!$stable(ext_lvl_q) |->
    $past(pins_s2_q.ext_clk) == ext_lvl_q) // see RULE6
    else $error("clock level flipped against input");
  quant_code_a: assert property (sar_done |-> sar_code == quant_ref(vin_hold_q)) // see RULE7
    else $error("code does not match quantiser");
  first_step_a: assert property (sar_done && vin_hold_q == 10'h002 |->
    sar_code == 8'h01) // see RULE8
    else $error("first transition not at half step");
  zero_code_a: assert property (sar_done && vin_hold_q < 10'h002 |->
    sar_code == 8'h00) // see RULE8
    else $error("code nonzero below half step");
  top_step_a: assert property (sar_done && vin_hold_q == 10'h3FA |->
    sar_code == 8'hFF) // see RULE9
    else $error("last transition misplaced");
  below_top_a: assert property (sar_done && vin_hold_q == 10'h3F9 |->
    sar_code == 8'hFE) // see RULE9
    else $error("code full scale too early");
  nibble_out_a: assert property (o_bus.oe |-> o_bus.data[7:4] == data_q[7:4]) // see RULE10
    else $error("nibble order broken");
  done_latch_a: assert property (sar_done |=> !done_n_q && data_q == $past(sar_code)) // see RULE13
    else $error("completion not latched");
  clear_read_a: assert property (rd_low && !sar_done |=> done_n_q) // see RULE13
    else $error("read did not clear done");
  strobe_hold_a: assert property (wr_low |=> !sar_done) // see RULE2
    else $error("conversion completed under a restart strobe");

  restart_c: cover property (sar_start && sar_busy);
  complete_c: cover property (sar_done ##[1:8] rd_low);
  free_run_c: cover property (!done_n_q ##[1:4] sar_start);

endmodule // sarc_conv_ctrl

// [verif/sarc_host_model.sv]
`timescale 1ns/1ps
module sarc_host_model
  import sarc_pkg::*;
(
  // Control
  input wire logic i_clock,
  input wire logic i_free_run,
  input wire logic i_ext_run,
  // Device side
  input wire sarc_bus_t i_bus,
  input wire logic i_conversion_done_n,
  output sarc_pins_t o_pins
);
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic init_q = 1'b0;
  logic ext_q = 1'b0;
  logic [1:0] div_q = 2'h0;

  // Free-run: select grounded, strobe tied to done
  assign o_pins.cs_n = i_free_run ? 1'b0 : cs_n;
  assign o_pins.wr_n = i_free_run ? i_conversion_done_n & ~init_q : wr_n;
  assign o_pins.rd_n = rd_n;
  assign o_pins.ext_clk = ext_q;

  // Bus clock divided by 8; stands still when off
  always @(negedge i_clock) begin
    if (i_ext_run) begin
      div_q <= div_q + 2'h1;
      ext_q <= (div_q == 2'h3) ? ~ext_q : ext_q;
    end
  end

  task automatic kick();
    @(negedge i_clock);
    init_q = 1'b1;
    repeat (3) @(negedge i_clock);
    init_q = 1'b0;
  endtask

  // Strobes stretched to three cycles so a loaded bus settles
  task automatic start();
    @(negedge i_clock);
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (3) @(negedge i_clock);
    cs_n = 1'b1;
    wr_n = 1'b1;
  endtask

  task automatic read(output logic [7:0] d);
    @(negedge i_clock);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (3) @(negedge i_clock);
    d = i_bus.oe ? i_bus.data : 8'hXX;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
endmodule // sarc_host_model

// [verif/sarc_conv_ctrl_tb.sv]
`timescale 1ns/1ps
module sarc_conv_ctrl_tb;
  import sarc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic sel_ext = 1'b0;
  logic free_run = 1'b0;
  logic ext_run = 1'b0;
  logic [SARC_VIN_W-1:0] vin = 10'h000;
  sarc_pins_t pins;
  sarc_bus_t bus;
  logic done_n;
  logic busy;
  logic last_q = 1'b1;
  logic [7:0] d;
  logic [7:0] keep [16];
  int falls = 0;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;

  always #4 i_clock = ~i_clock;

  sarc_host_model host (.i_clock(i_clock), .i_free_run(free_run), .i_ext_run(ext_run),
    .i_bus(bus), .i_conversion_done_n(done_n), .o_pins(pins));
  // Short RC period keeps a conversion near 64 cycles
  sarc_conv_ctrl #(.RC_HALF_CYC(4), .SCHMITT_CYC(2)) dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_pins(pins), .i_clk_sel_ext(sel_ext), .i_vin(vin), .o_bus(bus),
    .o_conversion_done_n(done_n), .o_busy(busy));

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    last_q <= done_n;
    if (last_q === 1'b1 && done_n === 1'b0) begin
      falls <= falls + 1;
    end
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] code_of(input int v);
    return ((v + 2) / 4 > 255) ? 8'hFF : 8'((v + 2) / 4);
  endfunction

  task automatic wait_done();
    int n = 0;
    while (done_n !== 1'b0 && n < 500) begin
      @(negedge i_clock);
      n++;
    end
    check({7'h00, done_n}, 8'h00);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    check(bus.data, SARC_DATA_RST);
    check({5'h00, bus.oe, busy, done_n}, 8'h01);
  endtask

  task automatic t_convert(input int v);
    vin = 10'(v);
    host.start();
    wait_done();
    host.read(d);
    check(d, code_of(v));
    repeat (2) @(negedge i_clock);
    check({7'h00, done_n}, 8'h01);
  endtask

  task automatic t_codes();
    int tbl [8] = '{0, 1, 2, 6, 729, 1017, 1018, 1023};
    foreach (tbl[i]) t_convert(tbl[i]);
  endtask

  task automatic t_abort();
    int f0;
    t_convert(100);
    f0 = falls;
    vin = 10'h258;
    host.start();
    repeat (4) @(negedge i_clock);
    check({7'h00, busy}, 8'h01);
    vin = 10'h320;
    host.start();
    host.read(d);
    check(d, code_of(100));
    wait_done();
    host.read(d);
    check(d, code_of(800));
    check(8'(falls - f0), 8'h01);
  endtask

  // Stopped external clock must stall the trials, proving the source switch
  task automatic t_ext();
    sel_ext = 1'b1;
    vin = 10'h2D9;
    host.start();
    repeat (100) @(negedge i_clock);
    check({6'h00, busy, done_n}, 8'h03);
    ext_run = 1'b1;
    wait_done();
    host.read(d);
    check(d, code_of(729));
    ext_run = 1'b0;
    sel_ext = 1'b0;
  endtask

  task automatic t_free();
    int f0;
    vin = 10'h3FA;
    free_run = 1'b1;
    f0 = falls;
    host.kick();
    for (int i = 0; i < 16; i++) begin
      wait_done();
      host.read(keep[i]);
    end
    check(8'(falls - f0), 8'h10);
    free_run = 1'b0;
    foreach (keep[i]) check(keep[i], 8'hFF);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge i_clock);
    i_rst = 1'b0;
    t_reset();
    t_codes();
    t_abort();
    t_ext();
    t_free();
    end_of_test();
  end
endmodule // sarc_conv_ctrl_tb
